//--- hw/segment_relocation_pkg.sv
// Package with offsets, fields, reset values and codes of the segment relocation unit.
package segment_relocation_pkg;

  // ************************************************************
  // Address widths
  // ************************************************************
  localparam int VIRTUAL_WIDTH = 16;
  localparam int PHYSICAL_WIDTH = 18;
  localparam int BASE_WIDTH = 12;
  localparam int BLOCK_INDEX_WIDTH = 7;
  localparam int IN_BLOCK_WIDTH = 6;
  localparam int SELECT_WIDTH = 3;
  localparam int ENTRY_COUNT = 48;
  localparam int ENTRY_INDEX_WIDTH = 6;

  // ************************************************************
  // Virtual address and status word field positions
  // ************************************************************
  localparam int SELECT_MSB = 15;
  localparam int SELECT_LSB = 13;
  localparam int BLOCK_MSB = 12;
  localparam int BLOCK_LSB = 6;
  localparam int OFFSET_MSB = 5;
  localparam int STATUS_MODE_MSB = 15;
  localparam int STATUS_MODE_LSB = 14;

  // ************************************************************
  // Fixed address values
  // ************************************************************
  localparam logic [2:0] IO_PAGE_SELECT = 3'h7;
  localparam logic [1:0] IO_PAGE_UPPER = 2'h3;
  localparam logic [1:0] LOW_PAGE_UPPER = 2'h0;

  // ************************************************************
  // Processor mode codes
  // ************************************************************
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPERVISOR = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h3;

  // ************************************************************
  // Register offsets and fields
  // ************************************************************
  localparam logic [11:0] CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] LAST_ADDRESS_OFFSET = 12'h008;
  localparam logic [3:0] MAP_PAGE = 4'h1;
  localparam logic [1:0] MAP_SET_UNUSED = 2'h3;
  localparam int CONTROL_ENABLE_BIT = 0;
  localparam int CONTROL_DATA_SPACE_BIT = 1;
  localparam logic CONTROL_ENABLE_RESET = 1'b0;
  localparam logic CONTROL_DATA_SPACE_RESET = 1'b1;
  localparam logic [11:0] BASE_RESET = 12'h000;

  // ************************************************************
  // Bus state
  // ************************************************************
  typedef enum logic [0:0] {bus_idle, bus_access} bus_state_type;

endpackage

//--- hw/segment_translate.sv
// Combinational address former for one virtual address.
`timescale 1ns/1ps
module segment_translate
  import segment_relocation_pkg::*;
(
  // Inputs.
  input wire logic [VIRTUAL_WIDTH-1:0] virtual_address,
  input wire logic [BASE_WIDTH-1:0] segment_base_block,
  input wire logic mapping_enable,
  // Result.
  output logic [PHYSICAL_WIDTH-1:0] physical_address
);

  // ************************************************************
  // Address forming
  // ************************************************************
  logic [BLOCK_INDEX_WIDTH-1:0] segment_block_index;
  logic [IN_BLOCK_WIDTH-1:0] in_block_offset;
  logic [BASE_WIDTH-1:0] physical_block;
  logic [BASE_WIDTH-1:0] index_wide;

  assign segment_block_index = virtual_address[BLOCK_MSB:BLOCK_LSB];
  assign in_block_offset = virtual_address[OFFSET_MSB:0];
  assign index_wide = {{(BASE_WIDTH-BLOCK_INDEX_WIDTH){1'b0}}, segment_block_index};
  assign physical_block = segment_base_block + index_wide;

  always_comb begin
    if (mapping_enable) begin
      physical_address = {physical_block, in_block_offset};
    end else if (virtual_address[SELECT_MSB:SELECT_LSB] == IO_PAGE_SELECT) begin
      physical_address = {IO_PAGE_UPPER, virtual_address};
    end else begin
      physical_address = {LOW_PAGE_UPPER, virtual_address};
    end
  end

endmodule

//--- hw/segment_address_relocation.sv
// Segment map, mode tracking, APB registers and registered address output.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module segment_address_relocation
  import segment_relocation_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor address request.
  input wire logic address_valid,
  input wire logic [VIRTUAL_WIDTH-1:0] virtual_address,
  input wire logic instruction_space,
  input wire logic vector_access,
  // Processor status update.
  input wire logic status_load,
  input wire logic [15:0] processor_status_word,
  // System bus address.
  output logic physical_valid,
  output logic [PHYSICAL_WIDTH-1:0] physical_address,
  // Mode outputs.
  output logic [1:0] stack_mode,
  output logic [1:0] map_mode
);

  // ************************************************************
  // Declarations
  // ************************************************************
  bus_state_type bus_state;
  logic mapping_enable;
  logic data_space_enable;
  logic [BASE_WIDTH-1:0] segment_map_entry [ENTRY_COUNT];
  logic [PHYSICAL_WIDTH-1:0] last_address;
  logic [1:0] set_select;
  logic space_select;
  logic [SELECT_WIDTH-1:0] segment_select_field;
  logic [ENTRY_INDEX_WIDTH-1:0] entry_index;
  logic [BASE_WIDTH-1:0] selected_base;
  logic [PHYSICAL_WIDTH-1:0] next_physical_address;
  logic map_hit;
  logic control_hit;
  logic status_hit;
  logic last_hit;
  logic [ENTRY_INDEX_WIDTH-1:0] bus_index;
  logic bus_write;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // ************************************************************
  // Entry selection
  // ************************************************************
  function automatic logic [1:0] set_of_mode(input logic [1:0] mode);
    logic [1:0] set_number;
    set_number = 2'h2;
    if (mode == MODE_KERNEL) begin
      set_number = 2'h0;
    end else if (mode == MODE_SUPERVISOR) begin
      set_number = 2'h1;
    end
    return set_number;
  endfunction

  always_comb begin
    if (vector_access) begin
      set_select = set_of_mode(MODE_KERNEL);
    end else begin
      set_select = set_of_mode(map_mode);
    end
  end

  assign space_select = ~instruction_space & data_space_enable;
  assign segment_select_field = virtual_address[SELECT_MSB:SELECT_LSB];
  assign entry_index = {set_select, space_select, segment_select_field};
  assign selected_base = segment_map_entry[entry_index];

  segment_translate translate (
    .virtual_address(virtual_address),
    .segment_base_block(selected_base),
    .mapping_enable(mapping_enable),
    .physical_address(next_physical_address)
  );

  // ************************************************************
  // Registered address output
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      physical_valid <= 1'b0;
      physical_address <= '0;
    end else begin
      physical_valid <= address_valid;
      if (address_valid) begin
        physical_address <= next_physical_address;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_address <= '0;
    end else if (address_valid) begin
      last_address <= next_physical_address;
    end
  end

  // ************************************************************
  // Mode tracking
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_mode <= MODE_KERNEL;
      map_mode <= MODE_KERNEL;
    end else if (status_load) begin
      stack_mode <= processor_status_word[STATUS_MODE_MSB:STATUS_MODE_LSB];
      map_mode <= processor_status_word[STATUS_MODE_MSB:STATUS_MODE_LSB];
    end
  end

  // ************************************************************
  // APB decode
  // ************************************************************
  assign control_hit = (paddr == CONTROL_OFFSET);
  assign status_hit = (paddr == STATUS_OFFSET);
  assign last_hit = (paddr == LAST_ADDRESS_OFFSET);
  assign map_hit = (paddr[11:8] == MAP_PAGE) && (paddr[7:6] != MAP_SET_UNUSED) && (paddr[1:0] == 2'h0);
  assign bus_index = paddr[7:2];
  assign bus_write = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (control_hit) begin
      next_prdata[CONTROL_ENABLE_BIT] = mapping_enable;
      next_prdata[CONTROL_DATA_SPACE_BIT] = data_space_enable;
    end else if (status_hit) begin
      next_prdata = {28'h0000000, stack_mode, map_mode};
    end else if (last_hit) begin
      next_prdata = {14'h0000, last_address};
    end else if (map_hit) begin
      next_prdata = {20'h00000, segment_map_entry[bus_index]};
    end else begin
      next_pslverr = 1'b1;
    end
    if (pwrite && status_hit) begin
      next_pslverr = 1'b1;
    end
    if (pwrite && last_hit) begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= bus_idle;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (bus_state)
        bus_idle: begin
          if (psel && !penable) begin
            bus_state <= bus_access;
            pready <= 1'b1;
            pslverr <= next_pslverr;
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
          end
        end
        bus_access: begin
          bus_state <= bus_idle;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= 32'h0000_0000;
        end
        default: begin
          bus_state <= bus_idle;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mapping_enable <= CONTROL_ENABLE_RESET;
      data_space_enable <= CONTROL_DATA_SPACE_RESET;
    end else if (bus_write && control_hit) begin
      mapping_enable <= pwdata[CONTROL_ENABLE_BIT];
      data_space_enable <= pwdata[CONTROL_DATA_SPACE_BIT];
    end
  end

  // ************************************************************
  // Segment map entries
  // ************************************************************
  for (genvar entry = 0; entry < ENTRY_COUNT; entry++) begin : map_entry
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        segment_map_entry[entry] <= BASE_RESET;
      end else if (bus_write && map_hit && bus_index == ENTRY_INDEX_WIDTH'(entry)) begin
        segment_map_entry[entry] <= pwdata[BASE_WIDTH-1:0];
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  chk_output_latency: assert property (@(posedge pclk) disable iff (!presetn)
    address_valid |=> physical_valid)
    else $error("Physical address did not follow a request by one cycle.");

  chk_io_page_extend: assert property (@(posedge pclk) disable iff (!presetn)
    (address_valid && !mapping_enable && virtual_address[15:13] == 3'h7)
    |=> physical_address[17:16] == 2'h3 && physical_address[15:0] == $past(virtual_address))
    else $error("I/O page address was not extended with ones.");

  chk_low_passthrough: assert property (@(posedge pclk) disable iff (!presetn)
    (address_valid && !mapping_enable && virtual_address[15:13] != 3'h7)
    |=> physical_address == {2'h0, $past(virtual_address)})
    else $error("Unmapped low address was altered.");

  chk_mapped_offset: assert property (@(posedge pclk) disable iff (!presetn)
    (address_valid && mapping_enable) |=> physical_address[5:0] == $past(virtual_address[5:0]))
    else $error("In-block offset was not carried through.");

  chk_mapped_block: assert property (@(posedge pclk) disable iff (!presetn)
    (address_valid && mapping_enable)
    |=> physical_address[17:6] == $past(selected_base) + {5'h00, $past(virtual_address[12:6])})
    else $error("Physical block is not base plus block index.");

  chk_vector_kernel: assert property (@(posedge pclk) disable iff (!presetn)
    vector_access |-> entry_index[5:4] == 2'h0)
    else $error("Vector access did not use the kernel set.");

  chk_data_disable: assert property (@(posedge pclk) disable iff (!presetn)
    (!data_space_enable || instruction_space) |-> entry_index[3] == 1'b0)
    else $error("Reference used data entries while it should not.");

  chk_mode_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_access && map_mode == 2'h3) |-> entry_index[5:4] == 2'h2)
    else $error("User mode did not select the user set.");

  chk_status_mode: assert property (@(posedge pclk) disable iff (!presetn)
    status_load |=> stack_mode == $past(processor_status_word[15:14]) && map_mode == stack_mode)
    else $error("Stack mode did not follow the new status word.");

  chk_select_field: assert property (@(posedge pclk) disable iff (!presetn)
    entry_index[2:0] == virtual_address[15:13])
    else $error("Entry select is not taken from the top address bits.");

  chk_bus_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pready) |=> pready ##1 !pready)
    else $error("APB ready did not come for exactly one cycle.");

  chk_output_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !address_valid |=> $stable(physical_address))
    else $error("Physical address changed without a request.");

  chk_last_follows: assert property (@(posedge pclk) disable iff (!presetn)
    address_valid |=> last_address == physical_address)
    else $error("Last address register differs from the bus address.");

  chk_kernel_set: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_access && map_mode == MODE_KERNEL) |-> entry_index[5:4] == 2'h0)
    else $error("Kernel mode did not select the kernel set.");

  chk_supervisor_set: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_access && map_mode == MODE_SUPERVISOR) |-> entry_index[5:4] == 2'h1)
    else $error("Supervisor mode did not select the supervisor set.");

  chk_data_entries: assert property (@(posedge pclk) disable iff (!presetn)
    (data_space_enable && !instruction_space) |-> entry_index[3] == 1'b1)
    else $error("Data reference did not use data entries.");

  chk_control_write: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_write && control_hit) |=> mapping_enable == $past(pwdata[CONTROL_ENABLE_BIT])
    && data_space_enable == $past(pwdata[CONTROL_DATA_SPACE_BIT]))
    else $error("Control bits did not take the written value.");

  chk_map_store: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_write && map_hit) |=> segment_map_entry[$past(bus_index)] == $past(pwdata[BASE_WIDTH-1:0]))
    else $error("Map entry did not take the written base.");

  chk_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !status_load |=> $stable(map_mode))
    else $error("Map mode changed without a status load.");

  chk_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pready && pwrite && (status_hit || last_hit)) |=> pready && pslverr)
    else $error("Write to a read-only register was not refused.");

  chk_read_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("Read data stood outside the access cycle.");

  cov_mapped_data: cover property (@(posedge pclk) disable iff (!presetn)
    address_valid && mapping_enable && !instruction_space && data_space_enable);

  cov_io_page: cover property (@(posedge pclk) disable iff (!presetn)
    address_valid && !mapping_enable && virtual_address[15:13] == 3'h7);

  cov_vector_then_user: cover property (@(posedge pclk) disable iff (!presetn)
    (vector_access && address_valid) ##1 status_load ##1 (map_mode == 2'h3));

  cov_map_write: cover property (@(posedge pclk) disable iff (!presetn)
    bus_write && map_hit);

  cov_data_space_off: cover property (@(posedge pclk) disable iff (!presetn)
    address_valid && mapping_enable && !data_space_enable && !instruction_space);

endmodule

//--- test/core_model.sv
// Processor core model that issues virtual addresses and status loads.
`timescale 1ns/1ps
module core_model
  import segment_relocation_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Address request.
  output logic address_valid,
  output logic [VIRTUAL_WIDTH-1:0] virtual_address,
  output logic instruction_space,
  output logic vector_access,
  // Status update.
  output logic status_load,
  output logic [15:0] processor_status_word
);
  // ****************************************
  // Request drivers
  // ****************************************
  initial begin
    address_valid = 1'b0;
    virtual_address = 16'h0000;
    instruction_space = 1'b0;
    vector_access = 1'b0;
    status_load = 1'b0;
    processor_status_word = 16'h0000;
  end

  // Presents one request for one cycle; called right after a rising edge.
  task automatic issue(input logic [15:0] vaddr, input logic isp, input logic vec);
    address_valid <= 1'b1;
    virtual_address <= vaddr;
    instruction_space <= isp;
    vector_access <= vec;
    @(posedge pclk);
  endtask

  // Idles the request; the stale address is inverted so nothing relies on it.
  task automatic rest(input int cycles);
    for (int i = 0; i < cycles; i++) begin
      address_valid <= 1'b0;
      virtual_address <= ~virtual_address;
      @(posedge pclk);
    end
  endtask

  // Loads a new status word whose two top bits carry the mode.
  task automatic load_status(input logic [1:0] mode);
    address_valid <= 1'b0;
    status_load <= 1'b1;
    processor_status_word <= {mode, 14'h1555};
    @(posedge pclk);
    status_load <= 1'b0;
    processor_status_word <= ~processor_status_word;
  endtask
endmodule

//--- test/test_segment_address_relocation.sv
// Self-checking testbench of the segment address relocation unit.
`timescale 1ns/1ps
module test_segment_address_relocation;
  import segment_relocation_pkg::*;
  logic pclk;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic address_valid;
  logic [15:0] virtual_address;
  logic instruction_space;
  logic vector_access;
  logic status_load;
  logic [15:0] processor_status_word;
  logic physical_valid;
  logic [17:0] physical_address;
  logic [1:0] stack_mode;
  logic [1:0] map_mode;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [11:0] entries [ENTRY_COUNT];
  logic map_en;
  logic dspace_en;
  logic [1:0] mode_m = 2'h0;
  logic exp_valid = 1'b0;
  logic [17:0] exp_phys = 18'h00000;

  segment_address_relocation u_segment_address_relocation (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .address_valid(address_valid), .virtual_address(virtual_address),
    .instruction_space(instruction_space), .vector_access(vector_access), .status_load(status_load),
    .processor_status_word(processor_status_word), .physical_valid(physical_valid),
    .physical_address(physical_address), .stack_mode(stack_mode), .map_mode(map_mode));

  core_model u_core_model (.pclk(pclk), .address_valid(address_valid), .virtual_address(virtual_address),
    .instruction_space(instruction_space), .vector_access(vector_access), .status_load(status_load),
    .processor_status_word(processor_status_word));

  // ****************************************
  // Expectation and comparison
  // ****************************************
  function automatic logic [17:0] expect_phys(input logic [15:0] vaddr, input logic isp, input logic vec);
    int set;
    int idx;
    logic [11:0] blk;
    if (!map_en) begin
      if (vaddr[15:13] == 3'h7) return {2'h3, vaddr};
      return {2'h0, vaddr};
    end
    set = vec ? 0 : (mode_m == 2'h0) ? 0 : (mode_m == 2'h1) ? 1 : 2;
    idx = set * 16 + ((!isp && dspace_en) ? 8 : 0) + int'(vaddr[15:13]);
    blk = entries[idx] + {5'h00, vaddr[12:6]};
    return {blk, vaddr[5:0]};
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  always @(posedge pclk) begin
    exp_valid <= presetn & address_valid;
    if (!presetn) begin
      exp_phys <= 18'h00000;
      mode_m <= 2'h0;
    end else begin
      if (address_valid) exp_phys <= expect_phys(virtual_address, instruction_space, vector_access);
      if (status_load) mode_m <= processor_status_word[15:14];
    end
  end

  always @(negedge pclk) begin
    if (presetn) begin
      check_flag(physical_valid, exp_valid);
      check_word({14'h0000, physical_address}, {14'h0000, exp_phys});
      check_word({28'h0000000, stack_mode, map_mode}, {28'h0000000, mode_m, mode_m});
    end
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic reg_check(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                           input logic [31:0] exp, input logic [31:0] mask, input logic exp_err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: no bus answer", $time);
      complete_run();
    end
    check_flag(pslverr, exp_err);
    if (!wr && !exp_err) check_word(prdata & mask, exp);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
    if (wr && !exp_err && addr == CONTROL_OFFSET) begin
      map_en = wd[0];
      dspace_en = wd[1];
    end
    if (wr && !exp_err && addr >= 12'h100) entries[(addr - 12'h100) >> 2] = wd[11:0];
    @(posedge pclk);
  endtask

  task automatic burst(input int n, input logic vec_ok);
    for (int i = 0; i < n; i++) begin
      u_core_model.issue(16'($urandom), 1'($urandom), vec_ok & 1'($urandom));
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    logic [1:0] modes [3];
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    map_en = CONTROL_ENABLE_RESET;
    dspace_en = CONTROL_DATA_SPACE_RESET;
    foreach (entries[i]) entries[i] = BASE_RESET;
    modes = '{2'h0, 2'h1, 2'h3};
    void'($urandom(85));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reg_check(1'b0, CONTROL_OFFSET, 32'h0, 32'h2, 32'h3, 1'b0);
    reg_check(1'b0, STATUS_OFFSET, 32'h0, 32'h0, 32'hf, 1'b0);
    reg_check(1'b1, STATUS_OFFSET, 32'hf, 32'h0, 32'h0, 1'b1);
    reg_check(1'b0, 12'h1c0, 32'h0, 32'h0, 32'h0, 1'b1);
    reg_check(1'b1, 12'h1fc, 32'h5, 32'h0, 32'h0, 1'b1);
    reg_check(1'b1, 12'h102, 32'h5, 32'h0, 32'h0, 1'b1);
    reg_check(1'b0, 12'h00c, 32'h0, 32'h0, 32'h0, 1'b1);
    $display("test registers_after_reset done");
    u_core_model.issue(16'hffff, 1'b0, 1'b0);
    u_core_model.issue(16'he000, 1'b1, 1'b0);
    u_core_model.issue(16'hdfff, 1'b0, 1'b1);
    u_core_model.issue(16'h0000, 1'b1, 1'b0);
    burst(20, 1'b1);
    u_core_model.rest(2);
    $display("test unmapped_addresses done");
    for (int i = 0; i < ENTRY_COUNT; i++) begin
      reg_check(1'b1, 12'(12'h100 + 4 * i), (i == 5) ? 32'hfff : $urandom, 32'h0, 32'h0, 1'b0);
    end
    for (int i = 0; i < ENTRY_COUNT; i++) begin
      reg_check(1'b0, 12'(12'h100 + 4 * i), 32'h0, {20'h0, entries[i]}, 32'hfff, 1'b0);
    end
    reg_check(1'b1, CONTROL_OFFSET, 32'h3, 32'h0, 32'h0, 1'b0);
    $display("test map_programming done");
    foreach (modes[m]) begin
      u_core_model.load_status(modes[m]);
      u_core_model.issue(16'hbfff, 1'b1, 1'b1);
      u_core_model.issue(16'hbfff, 1'b1, 1'b0);
      burst(30, 1'b1);
      u_core_model.rest(1);
    end
    reg_check(1'b0, LAST_ADDRESS_OFFSET, 32'h0, {14'h0, exp_phys}, 32'h3ffff, 1'b0);
    $display("test mapped_modes done");
    reg_check(1'b1, CONTROL_OFFSET, 32'h1, 32'h0, 32'h0, 1'b0);
    burst(30, 1'b0);
    u_core_model.rest(2);
    $display("test data_space_off done");
    complete_run();
  end
endmodule
